// file: core/chip_select_pkg.sv
// ****************************************************************
// Chip-select decoder constants
// ****************************************************************
package chip_select_pkg;

    localparam int CHANNELS = 4;

    // Register port indices
    localparam logic [3:0] OFFSET_BASE0 = 4'h0;
    localparam logic [3:0] OFFSET_OPTIONS0 = 4'h4;
    localparam logic [3:0] OFFSET_CONTROL = 4'h8;

    // select_base fields
    localparam int BASE_SPACE_HI = 15;
    localparam int BASE_SPACE_LO = 13;
    localparam int BASE_ADDR_HI = 12;
    localparam int BASE_ADDR_LO = 2;
    localparam int BASE_DIR_BIT = 1;
    localparam int BASE_ENABLE_BIT = 0;

    // select_options fields
    localparam int OPT_ACK_HI = 15;
    localparam int OPT_ACK_LO = 13;
    localparam int OPT_MASK_HI = 12;
    localparam int OPT_MASK_LO = 2;
    localparam int OPT_DIR_MASK_BIT = 1;
    localparam int OPT_SPACE_CMP_BIT = 0;

    // system_control_word fields
    localparam int CTRL_TRAP_EN_BIT = 0;
    localparam int CTRL_EXTRA_WAIT_BIT = 1;
    localparam int CTRL_WP_FLAG_BIT = 8;

    // Reset values: supervisor program space, base 0, read, enabled on 0
    localparam logic [15:0] BASE0_RESET = 16'hC001;
    localparam logic [15:0] BASE_RESET = 16'hC000;
    // Six wait states, full mask, direction masked, space compared
    localparam logic [15:0] OPTIONS_RESET = 16'hDFFD;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    localparam logic [2:0] SPACE_RESERVED = 3'h7;
    localparam logic [2:0] ACK_EXTERNAL = 3'h7;

    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_COUNT,
        CYC_HOLD
    } cycle_state_t;

endpackage : chip_select_pkg

// file: core/chip_select_channel.sv
`timescale 1ns/1ps
// ****************************************************************
// One channel's address, space and direction comparator
// ****************************************************************
module chip_select_channel
    import chip_select_pkg::*;
(
    input wire logic [15:0] select_base,
    input wire logic [15:0] select_options,
    input wire logic [23:13] bus_addr,
    input wire logic [2:0] bus_space,
    input wire logic bus_write,
    output logic hit,
    output logic pass,
    output logic violation
);

    logic [10:0] addr_diff;
    logic addr_ok;
    logic space_ok;
    logic dir_ok;
    logic enabled;
    logic dir_checked;

    always_comb begin
        enabled = select_base[BASE_ENABLE_BIT];
        addr_diff = (bus_addr ^ select_base[BASE_ADDR_HI:BASE_ADDR_LO])
            & select_options[OPT_MASK_HI:OPT_MASK_LO];
        addr_ok = (addr_diff == 11'h000);
        space_ok = (select_base[BASE_SPACE_HI:BASE_SPACE_LO] != SPACE_RESERVED)
            && (bus_space != SPACE_RESERVED)
            && (!select_options[OPT_SPACE_CMP_BIT]
                || bus_space == select_base[BASE_SPACE_HI:BASE_SPACE_LO]);
        dir_checked = select_options[OPT_DIR_MASK_BIT];
        dir_ok = !dir_checked || (bus_write == select_base[BASE_DIR_BIT]);
        hit = enabled && addr_ok && space_ok;
        pass = hit && dir_ok;
        violation = hit && dir_checked && !select_base[BASE_DIR_BIT] && bus_write;
    end

endmodule : chip_select_channel

// file: core/chip_select_decoder.sv
`timescale 1ns/1ps
// Overview of operation
// - Reserved space code 111 never selects
// - Space codes reset to supervisor program
// - Base bits 12..2 compare address 23..13
// - Base addresses reset to zero
// - Direction bit restricts reads or writes
// - Protected write sets flag, optional bus error
// - Enable bit; only channel zero after reset
// - Registers writable while channel enabled
// - Ack code gives zero to six waits
// - External ack code: never drive ack
// - Ack field resets to six waits
// - Waits counted on own clock
// - Mask bit zero makes line don't-care
// - Address masks reset to all ones
// - Direction mask zero allows both directions
// - Space compare bit gates space match
// - Bus space 111 never selects
// - Single select, channel zero highest priority
// - Violation cycle keeps select deasserted
module chip_select_decoder
    import chip_select_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [23:13] bus_addr,
    input wire logic [2:0] bus_space,
    input wire logic bus_write,
    input wire logic bus_strobe_n,
    input wire logic internal_access,
    input wire logic outside_master,
    input wire logic ack_in_n,
    output logic [3:0] select_n,
    output logic ack_out_n,
    output logic ack_oe_n,
    output logic bus_error_n
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int SYNC_W = 11 + 3 + 1 + 1 + 1 + 1 + 1;

    logic [SYNC_W-1:0] pins_meta_q;
    logic [SYNC_W-1:0] pins_q;
    logic [23:13] addr_s;
    logic [2:0] space_s;
    logic write_s;
    logic strobe_s;
    logic internal_s;
    logic outside_s;
    logic ack_in_s;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_meta_q <= '0;
            pins_q <= '0;
        end else begin
            pins_meta_q <= {bus_addr, bus_space, bus_write, ~bus_strobe_n,
                internal_access, outside_master, ~ack_in_n};
            pins_q <= pins_meta_q;
        end
    end

    always_comb begin
        {addr_s, space_s, write_s, strobe_s, internal_s, outside_s, ack_in_s} = pins_q;
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [15:0] base_q [CHANNELS];
    logic [15:0] options_q [CHANNELS];
    logic trap_enable_q;
    logic extra_wait_q;
    logic wp_flag_q;
    logic wp_event;
    logic [15:0] reg_rdata_q;

    function automatic logic is_channel_reg(input logic [3:0] addr, input logic [3:0] first,
        input int ch);
        is_channel_reg = (addr == first + 4'(ch));
    endfunction : is_channel_reg

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_regs
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    base_q[gi] <= (gi == 0) ? BASE0_RESET : BASE_RESET;
                    options_q[gi] <= OPTIONS_RESET;
                end else if (reg_wr) begin
                    // Writes land regardless of the enable bit
                    if (is_channel_reg(reg_addr, OFFSET_BASE0, gi)) begin
                        base_q[gi] <= reg_wdata;
                    end
                    if (is_channel_reg(reg_addr, OFFSET_OPTIONS0, gi)) begin
                        options_q[gi] <= reg_wdata;
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Control bits and write-protect flag
    // ****************************************************************

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_enable_q <= CONTROL_RESET[CTRL_TRAP_EN_BIT];
            extra_wait_q <= CONTROL_RESET[CTRL_EXTRA_WAIT_BIT];
        end else if (reg_wr && reg_addr == OFFSET_CONTROL) begin
            trap_enable_q <= reg_wdata[CTRL_TRAP_EN_BIT];
            extra_wait_q <= reg_wdata[CTRL_EXTRA_WAIT_BIT];
        end
    end

    // Sticky flag, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_flag_q <= CONTROL_RESET[CTRL_WP_FLAG_BIT];
        end else if (wp_event) begin
            wp_flag_q <= 1'b1;
        end else if (reg_wr && reg_addr == OFFSET_CONTROL && reg_wdata[CTRL_WP_FLAG_BIT]) begin
            wp_flag_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************

    // Control word as software reads it
    function automatic logic [15:0] control_word(input logic trap, input logic extra,
        input logic flag);
        logic [15:0] w;
        w = 16'h0000;
        w[CTRL_TRAP_EN_BIT] = trap;
        w[CTRL_EXTRA_WAIT_BIT] = extra;
        w[CTRL_WP_FLAG_BIT] = flag;
        control_word = w;
    endfunction : control_word

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr < OFFSET_OPTIONS0) begin
                reg_rdata_q <= base_q[reg_addr[1:0]];
            end else if (reg_addr < OFFSET_CONTROL) begin
                reg_rdata_q <= options_q[reg_addr[1:0]];
            end else if (reg_addr == OFFSET_CONTROL) begin
                reg_rdata_q <= control_word(trap_enable_q, extra_wait_q, wp_flag_q);
            end else begin
                reg_rdata_q <= 16'h0000;
            end
        end else begin
            reg_rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata = reg_rdata_q;

    // ****************************************************************
    // Channel comparators
    // ****************************************************************
    logic [CHANNELS-1:0] hit;
    logic [CHANNELS-1:0] pass;
    logic [CHANNELS-1:0] violation;

    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
            chip_select_channel u_channel (
                .select_base(base_q[gi]),
                .select_options(options_q[gi]),
                .bus_addr(addr_s),
                .bus_space(space_s),
                .bus_write(write_s),
                .hit(hit[gi]),
                .pass(pass[gi]),
                .violation(violation[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Priority between channels
    // ****************************************************************

    // Lowest set index as one-hot
    function automatic logic [CHANNELS-1:0] first_set(input logic [CHANNELS-1:0] v);
        logic [CHANNELS-1:0] r;
        r = '0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        first_set = r;
    endfunction : first_set

    logic [CHANNELS-1:0] winner;
    logic [CHANNELS-1:0] blocked;
    logic any_pass;
    logic protect_hit;
    logic [2:0] ack_code;
    logic [2:0] wait_load;

    always_comb begin
        winner = first_set(pass);
        blocked = first_set(violation);
        any_pass = |pass;
        protect_hit = !any_pass && (|violation);
        ack_code = ACK_EXTERNAL;
        for (int i = 0; i < CHANNELS; i++) begin
            if (winner[i]) begin
                ack_code = options_q[i][OPT_ACK_HI:OPT_ACK_LO];
            end
        end
        // Code six plus the extra wait still fits three bits
        wait_load = ack_code + 3'((outside_s && extra_wait_q) ? 1 : 0);
    end

    // ****************************************************************
    // Bus cycle sequencer
    // ****************************************************************
    cycle_state_t state_q;
    logic [2:0] wait_q;
    logic [3:0] select_n_q;
    logic ack_out_n_q;
    logic ack_oe_n_q;
    logic bus_error_n_q;
    logic cycle_start;

    // Strobe must be seen high again before a new cycle starts
    assign cycle_start = (state_q == CYC_IDLE) && strobe_s && !internal_s;
    assign wp_event = cycle_start && protect_hit && (|blocked);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CYC_IDLE;
            wait_q <= 3'h0;
        end else begin
            unique case (state_q)
                CYC_IDLE: begin
                    if (cycle_start) begin
                        if (any_pass && ack_code != ACK_EXTERNAL && wait_load != 3'h0) begin
                            wait_q <= wait_load;
                            state_q <= CYC_COUNT;
                        end else begin
                            state_q <= CYC_HOLD;
                        end
                    end
                end
                CYC_COUNT: begin
                    if (!strobe_s) begin
                        state_q <= CYC_IDLE;
                    end else begin
                        wait_q <= wait_q - 3'h1;
                        if (wait_q == 3'h1) begin
                            state_q <= CYC_HOLD;
                        end
                    end
                end
                CYC_HOLD: begin
                    if (!strobe_s) begin
                        state_q <= CYC_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Select lines
    // ****************************************************************

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            select_n_q <= 4'hF;
        end else if (cycle_start) begin
            select_n_q <= ~winner;
        end else if (!strobe_s) begin
            select_n_q <= 4'hF;
        end
    end

    // ****************************************************************
    // Acknowledge and bus error
    // ****************************************************************

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_out_n_q <= 1'b1;
            ack_oe_n_q <= 1'b1;
        end else if (!strobe_s) begin
            ack_out_n_q <= 1'b1;
            ack_oe_n_q <= 1'b1;
        end else if (cycle_start && any_pass && ack_code != ACK_EXTERNAL) begin
            // Pin driven high until the count runs out
            ack_oe_n_q <= 1'b0;
            ack_out_n_q <= (wait_load != 3'h0);
        end else if (state_q == CYC_COUNT && wait_q == 3'h1) begin
            ack_out_n_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_error_n_q <= 1'b1;
        end else if (!strobe_s) begin
            bus_error_n_q <= 1'b1;
        end else if (wp_event && trap_enable_q) begin
            bus_error_n_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Output ports
    // ****************************************************************

    assign select_n = select_n_q;
    assign ack_out_n = ack_out_n_q;
    assign ack_oe_n = ack_oe_n_q;
    assign bus_error_n = bus_error_n_q;

    // Synchronised external ack is only observed, never passed on
    logic ack_seen_unused;
    assign ack_seen_unused = ack_in_s;

endmodule : chip_select_decoder

// file: testbench/chip_select_properties.sv
`timescale 1ns/1ps
// **********
// Decoder port properties
// **********
module chip_select_properties
    import chip_select_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [2:0] bus_space,
    input wire logic bus_strobe_n,
    input wire logic outside_master,
    input wire logic [3:0] select_n,
    input wire logic ack_out_n,
    input wire logic ack_oe_n,
    input wire logic bus_error_n
);
    logic [2:0] code_q [CHANNELS];
    logic [1:0] ctrl_q;
    logic [4:0] cnt_q;
    logic [2:0] code;
    logic [4:0] waits;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Shadow of acknowledge codes and control bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= '{default: OPTIONS_RESET[OPT_ACK_HI:OPT_ACK_LO]};
            ctrl_q <= 2'h0;
        end else if (reg_wr && reg_addr[3:2] == 2'h1) begin
            code_q[reg_addr[1:0]] <= reg_wdata[15:13];
        end else if (reg_wr && reg_addr == OFFSET_CONTROL) begin
            ctrl_q <= reg_wdata[1:0];
        end
    end
    // Cycles since the select went active
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= &select_n ? 5'h00 : cnt_q + 5'h01;
        end
    end
    assign code = !select_n[0] ? code_q[0] : !select_n[1] ? code_q[1] :
        !select_n[2] ? code_q[2] : code_q[3];
    assign waits = {2'h0, code} + {4'h0, outside_master & ctrl_q[1]};
    sequence sel_start;
        $fell(&select_n);
    endsequence
    chk_single_select: assert property ($onehot0(~select_n))
        else $error("more than one select line active");
    chk_space_never: assert property (!(&select_n) |-> bus_space != SPACE_RESERVED)
        else $error("select active on reserved space");
    chk_strobe_cause: assert property (sel_start |-> $past(bus_strobe_n, 2) == 1'b0)
        else $error("select without strobe");
    chk_ack_timing: assert property ($fell(ack_out_n) |-> cnt_q == waits)
        else $error("acknowledge after wrong wait count");
    chk_ext_ack: assert property (!(&select_n) && code == ACK_EXTERNAL |-> ack_oe_n)
        else $error("acknowledge driven for external code");
    chk_internal_ack: assert property ((sel_start ##0 (code != ACK_EXTERNAL)) |-> !ack_oe_n)
        else $error("acknowledge pin not driven");
    chk_ack_owner: assert property (!ack_out_n |-> !ack_oe_n && !(&select_n))
        else $error("acknowledge without select");
    chk_error_quiet: assert property (!bus_error_n |-> &select_n && ctrl_q[0])
        else $error("bus error with select or trap off");
    chk_cycle_release: assert property ($rose(bus_strobe_n) |->
        ##[1:3] (&select_n && ack_oe_n && bus_error_n))
        else $error("outputs not released");
endmodule : chip_select_properties
bind chip_select_decoder chip_select_properties props (.ref_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .bus_space, .bus_strobe_n, .outside_master, .select_n,
    .ack_out_n, .ack_oe_n, .bus_error_n);

// file: testbench/far_device_model.sv
`timescale 1ns/1ps
// **********
// Memory with its own acknowledge
// **********
module far_device_model #(
    parameter int DELAY = 2
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] select_n,
    input wire logic ack_oe_n,
    output logic ack_drive_n
);
    int count;
    // Only regions left to outside logic
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n || &select_n || !ack_oe_n) begin
            count <= 0;
            ack_drive_n <= 1'b1;
        end else begin
            count <= count + 1;
            ack_drive_n <= count < DELAY;
        end
    end
endmodule : far_device_model

// file: testbench/chip_select_decoder_tb.sv
`timescale 1ns/1ps
// **********
// Decoder bench
// **********
module chip_select_decoder_tb
    import chip_select_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [23:13] bus_addr = 11'h000;
    logic [2:0] bus_space = 3'h6;
    logic bus_write = 1'b0;
    logic bus_strobe_n = 1'b1;
    logic internal_access = 1'b0;
    logic outside_master = 1'b0;
    logic [15:0] reg_rdata;
    logic [3:0] select_n;
    logic ack_out_n, ack_oe_n, bus_error_n, ack_drive_n, ack_wire_n;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    always #50 ref_clk = ~ref_clk;
    assign ack_wire_n = ack_drive_n & (ack_oe_n | ack_out_n);
    chip_select_decoder dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .bus_addr, .bus_space, .bus_write, .bus_strobe_n, .internal_access,
        .outside_master, .ack_in_n(ack_wire_n), .select_n, .ack_out_n, .ack_oe_n,
        .bus_error_n);
    far_device_model #(.DELAY(2)) peer (.ref_clk, .rst_n, .select_n, .ack_oe_n,
        .ack_drive_n);
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", reg_rdata, e);
    endtask : rd
    // One bus cycle; e is select, ack enable, bus error; n waits, 12 for none
    task automatic cyc(input logic [23:13] a, input logic [2:0] sp, input logic w,
        input logic [5:0] e, input logic [15:0] n);
        int k;
        @(posedge ref_clk);
        bus_addr <= a;
        bus_space <= sp;
        bus_write <= w;
        bus_strobe_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 check("select", {10'h000, select_n, ack_oe_n, bus_error_n}, {10'h000, e});
        for (k = 0; k < 12 && ack_out_n !== 1'b0; k++) begin
            @(posedge ref_clk);
            #1;
        end
        check("waits", 16'(k), n);
        @(posedge ref_clk);
        bus_strobe_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 check("idle", {9'h000, select_n, ack_oe_n, ack_out_n, bus_error_n}, 16'h007F);
    endtask : cyc
    task automatic reset_values();
        wr(4'h9, 16'hFFFF);
        for (int i = 0; i < 10; i++) begin
            rd(4'(i), i == 0 ? BASE0_RESET : i < 4 ? BASE_RESET :
                i < 8 ? OPTIONS_RESET : 16'h0000);
        end
    endtask : reset_values
    task automatic boot_region();
        cyc(11'h000, 3'h6, 1'b0, 6'h39, 16'h0006);
        cyc(11'h000, 3'h6, 1'b1, 6'h39, 16'h0006);
        cyc(11'h001, 3'h6, 1'b0, 6'h3F, 16'h000C);
        cyc(11'h000, 3'h5, 1'b0, 6'h3F, 16'h000C);
        @(posedge ref_clk);
        internal_access <= 1'b1;
        cyc(11'h000, 3'h6, 1'b0, 6'h3F, 16'h000C);
        @(posedge ref_clk);
        internal_access <= 1'b0;
    endtask : boot_region
    task automatic wait_codes();
        for (int c = 0; c < 8; c++) begin
            wr(OFFSET_OPTIONS0, {3'(c), 13'h1FFC});
            cyc(11'h000, 3'h0, 1'b0, c == 7 ? 6'h3B : 6'h39,
                c == 7 ? 16'h000C : 16'(c));
        end
        wr(OFFSET_OPTIONS0, 16'h5FFC);
        wr(OFFSET_CONTROL, 16'h0002);
        cyc(11'h000, 3'h0, 1'b0, 6'h39, 16'h0002);
        @(posedge ref_clk);
        outside_master <= 1'b1;
        cyc(11'h000, 3'h0, 1'b0, 6'h39, 16'h0003);
        @(posedge ref_clk);
        outside_master <= 1'b0;
        wr(OFFSET_CONTROL, 16'h0000);
    endtask : wait_codes
    task automatic space_codes();
        cyc(11'h000, 3'h7, 1'b0, 6'h3F, 16'h000C);
        wr(OFFSET_OPTIONS0, 16'h1FFC);
        wr(OFFSET_BASE0, 16'hE001);
        cyc(11'h000, 3'h0, 1'b0, 6'h3F, 16'h000C);
    endtask : space_codes
    task automatic mask_priority();
        wr(OFFSET_OPTIONS0, 16'h1FF8);
        wr(OFFSET_BASE0, 16'h0001);
        cyc(11'h001, 3'h0, 1'b0, 6'h39, 16'h0000);
        cyc(11'h002, 3'h0, 1'b0, 6'h3F, 16'h000C);
        wr(OFFSET_OPTIONS0 + 4'h1, 16'h1FF8);
        wr(OFFSET_BASE0 + 4'h1, 16'h0001);
        cyc(11'h001, 3'h0, 1'b0, 6'h39, 16'h0000);
        wr(OFFSET_BASE0, 16'h0000);
        cyc(11'h001, 3'h0, 1'b0, 6'h35, 16'h0000);
    endtask : mask_priority
    task automatic direction();
        wr(OFFSET_OPTIONS0 + 4'h1, 16'h1FFE);
        wr(OFFSET_BASE0 + 4'h1, 16'h0401);
        cyc(11'h100, 3'h0, 1'b0, 6'h35, 16'h0000);
        cyc(11'h100, 3'h0, 1'b1, 6'h3F, 16'h000C);
        rd(OFFSET_CONTROL, 16'h0100);
        wr(OFFSET_CONTROL, 16'h0101);
        rd(OFFSET_CONTROL, 16'h0001);
        cyc(11'h100, 3'h0, 1'b1, 6'h3E, 16'h000C);
        wr(OFFSET_BASE0 + 4'h1, 16'h0403);
        cyc(11'h100, 3'h0, 1'b1, 6'h35, 16'h0000);
        cyc(11'h100, 3'h0, 1'b0, 6'h3F, 16'h000C);
    endtask : direction
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        reset_values();
        boot_region();
        wait_codes();
        space_codes();
        mask_priority();
        direction();
        end_of_test();
    end
endmodule : chip_select_decoder_tb
